// File: design/branch_unit_pkg.sv
// Purpose: Shared constants for the branch resolution block
// Assumes: 32-bit instruction and address width
// Notes:   Register offsets are byte addresses on the APB bus
package branch_unit_pkg;
    localparam int          XLEN            = 32;
    localparam logic [5:0]  OPC_REG_IMM     = 6'h01;
    localparam logic [5:0]  OPC_COP1        = 6'h11;
    localparam logic [4:0]  RT_NONNEG_LINK  = 5'h11;
    localparam logic [4:0]  COP1_BRANCH_SUB = 5'h08;
    localparam logic [4:0]  LINK_REG        = 5'h1f;
    localparam logic [31:0] LINK_STEP       = 32'h00000008;
    localparam logic [31:0] SLOT_STEP       = 32'h00000004;
    localparam int          OPC_MSB         = 31;
    localparam int          OPC_LSB         = 26;
    localparam int          RS_MSB          = 25;
    localparam int          RS_LSB          = 21;
    localparam int          RT_MSB          = 20;
    localparam int          RT_LSB          = 16;
    localparam int          CC_MSB          = 20;
    localparam int          CC_LSB          = 18;
    localparam int          ND_BIT          = 17;
    localparam int          TF_BIT          = 16;
    localparam int          OFS_MSB         = 15;
    // Register offsets
    localparam logic [7:0]  OFS_STATUS      = 8'h00;
    localparam logic [7:0]  OFS_MASK        = 8'h04;
    localparam logic [7:0]  OFS_CTRL        = 8'h08;
    localparam logic [7:0]  OFS_LAST_TARGET = 8'h0c;
    // Status bit positions
    localparam int          ST_TAKEN        = 0;
    localparam int          ST_NULLIFY      = 1;
    localparam int          ST_CPU_EXC      = 2;
    localparam int          ST_RSVD_EXC     = 3;
    localparam int          ST_UNIMPL_EXC   = 4;
    localparam int          ST_BITS         = 5;
    // Control bit positions
    localparam int          CTL_FPU_USABLE  = 0;
    localparam int          CTL_FPU_PRESENT = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h3;
    localparam logic [4:0]  MASK_RESET      = 5'h00;
endpackage

// File: design/branch_link_fp_cond_unit.sv
// Purpose: Resolves link and FP-condition branches, delay slot and exceptions
// Assumes: One instruction presented per cycle with issue_valid; APB register access
// Notes:   The redirect arrives one cycle after evaluation, behind the delay slot
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Decode opcode 000001, rs zero, selector 10001 as unconditional branch with link.
// - Target is delay-slot address plus sign-extended offset shifted left two.
// - Link form writes instruction address plus 8 into register 31.
// - Delay slot runs first; PC redirect happens the cycle after evaluation.
// - False forms branch only when the selected condition bit is 0.
// - True forms branch only when the selected condition bit is 1.
// - Likely forms nullify the delay slot when not taken, run it when taken.
// - Eight condition bits; the select field picks one, short form means bit 0.
// - Tested condition bits are those written by the FP compare.
// - FP branches may raise coprocessor-unusable or reserved-instruction; link raises none.
// - FP branches report unimplemented operation when the FP unit cannot do it.
module branch_link_fp_cond_unit
#(
    parameter int CC_COUNT = 8
)
(
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Issue stage
    input  wire logic                issue_valid,
    input  wire logic [31:0]         issue_instr,
    input  wire logic [31:0]         issue_pc,
    // FP unit
    input  wire logic [CC_COUNT-1:0] fp_condition_bit,
    input  wire logic                fp_unimpl,
    // Fetch path
    output logic                     redirect_valid,
    output logic      [31:0]         redirect_pc,
    output logic                     slot_nullify,
    // Register file link write
    output logic                     link_we,
    output logic      [4:0]          link_addr,
    output logic      [31:0]         link_data,
    // Exceptions
    output logic                     exc_cop_unusable,
    output logic                     exc_reserved,
    output logic                     exc_fp_unimpl,
    // Interrupt
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    logic [5:0]  opc;
    logic        is_link_idiom;
    logic        is_fp_branch;
    logic        cc_in_range;
    logic [2:0]  cond_select_field;
    logic        true_false_select;
    logic        nullify_slot_select;
    logic        fp_cond_signal;
    logic        cond_taken;
    logic [31:0] target_offset;
    logic [31:0] branch_target;
    logic        fpu_usable;
    logic        fpu_present;

    assign opc = issue_instr[branch_unit_pkg::OPC_MSB:branch_unit_pkg::OPC_LSB];

    assign is_link_idiom = issue_valid
        && opc == branch_unit_pkg::OPC_REG_IMM
        && issue_instr[branch_unit_pkg::RS_MSB:branch_unit_pkg::RS_LSB] == 5'h00
        && issue_instr[branch_unit_pkg::RT_MSB:branch_unit_pkg::RT_LSB]
           == branch_unit_pkg::RT_NONNEG_LINK;

    assign is_fp_branch = issue_valid
        && opc == branch_unit_pkg::OPC_COP1
        && issue_instr[branch_unit_pkg::RS_MSB:branch_unit_pkg::RS_LSB]
           == branch_unit_pkg::COP1_BRANCH_SUB;

    assign cond_select_field   = issue_instr[branch_unit_pkg::CC_MSB:branch_unit_pkg::CC_LSB];
    assign true_false_select   = issue_instr[branch_unit_pkg::TF_BIT];
    assign nullify_slot_select = issue_instr[branch_unit_pkg::ND_BIT];

    // A narrowed unit flags selectors beyond its condition bits as reserved
    assign cc_in_range = 32'(cond_select_field) < CC_COUNT;

    // Live compare result this cycle, not a stale copy
    assign fp_cond_signal = cc_in_range ? fp_condition_bit[cond_select_field] : 1'b0;

    // One comparison covers false and true forms
    assign cond_taken = (fp_cond_signal == true_false_select);

    assign target_offset = {{(32 - 18){issue_instr[branch_unit_pkg::OFS_MSB]}},
                            issue_instr[branch_unit_pkg::OFS_MSB:0], 2'b00};
    assign branch_target = issue_pc + branch_unit_pkg::SLOT_STEP + target_offset;

    ////////////////////////////////////////////////////////////////////////////
    // Exception classification
    logic ev_cop_unusable;
    logic ev_reserved;
    logic ev_unimpl;
    logic fp_ok;
    logic ev_taken;
    logic ev_nullify;

    assign ev_cop_unusable = is_fp_branch && !fpu_usable;
    assign ev_reserved     = is_fp_branch && fpu_usable && (!fpu_present || !cc_in_range);
    assign ev_unimpl       = is_fp_branch && fpu_usable && fpu_present && cc_in_range
                             && fp_unimpl;
    assign fp_ok           = is_fp_branch && fpu_usable && fpu_present && cc_in_range
                             && !fp_unimpl;
    assign ev_taken        = is_link_idiom || (fp_ok && cond_taken);
    assign ev_nullify      = fp_ok && nullify_slot_select && !cond_taken;

    ////////////////////////////////////////////////////////////////////////////
    // Delay slot and redirect
    // The redirect lands one cycle late, so the already fetched slot still runs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            redirect_valid <= 1'b0;
            redirect_pc    <= 32'h00000000;
            slot_nullify   <= 1'b0;
        end
        else
        begin
            redirect_valid <= ev_taken;
            redirect_pc    <= ev_taken ? branch_target : redirect_pc;
            // Slot kills itself only for a not-taken likely form
            slot_nullify   <= ev_nullify;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_we   <= 1'b0;
            link_addr <= 5'h00;
            link_data <= 32'h00000000;
        end
        else
        begin
            link_we   <= is_link_idiom;
            link_addr <= branch_unit_pkg::LINK_REG;
            if (is_link_idiom)
                link_data <= issue_pc + branch_unit_pkg::LINK_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Exception outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exc_cop_unusable <= 1'b0;
            exc_reserved     <= 1'b0;
            exc_fp_unimpl    <= 1'b0;
        end
        else
        begin
            exc_cop_unusable <= ev_cop_unusable;
            exc_reserved     <= ev_reserved;
            exc_fp_unimpl    <= ev_unimpl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers and interrupt
    logic [branch_unit_pkg::ST_BITS-1:0] status_reg;
    logic [branch_unit_pkg::ST_BITS-1:0] mask_reg;
    logic [1:0]                          ctrl_reg;
    logic [31:0]                         last_target_reg;
    logic [branch_unit_pkg::ST_BITS-1:0] ev_vec;
    logic                                wr_en;
    logic                                rd_en;
    logic                                addr_ok;

    assign fpu_usable  = ctrl_reg[branch_unit_pkg::CTL_FPU_USABLE];
    assign fpu_present = ctrl_reg[branch_unit_pkg::CTL_FPU_PRESENT];
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign addr_ok = paddr == branch_unit_pkg::OFS_STATUS || paddr == branch_unit_pkg::OFS_MASK
                     || paddr == branch_unit_pkg::OFS_CTRL
                     || paddr == branch_unit_pkg::OFS_LAST_TARGET;

    always_comb
    begin
        ev_vec                              = '0;
        ev_vec[branch_unit_pkg::ST_TAKEN]      = ev_taken;
        ev_vec[branch_unit_pkg::ST_NULLIFY]    = ev_nullify;
        ev_vec[branch_unit_pkg::ST_CPU_EXC]    = ev_cop_unusable;
        ev_vec[branch_unit_pkg::ST_RSVD_EXC]   = ev_reserved;
        ev_vec[branch_unit_pkg::ST_UNIMPL_EXC] = ev_unimpl;
    end

    // Set beats a same-cycle write-one-to-clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_reg <= '0;
        else if (wr_en && paddr == branch_unit_pkg::OFS_STATUS)
            status_reg <= (status_reg & ~pwdata[branch_unit_pkg::ST_BITS-1:0]) | ev_vec;
        else
            status_reg <= status_reg | ev_vec;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_reg <= branch_unit_pkg::MASK_RESET;
            ctrl_reg <= branch_unit_pkg::CTRL_RESET;
        end
        else if (wr_en)
        begin
            if (paddr == branch_unit_pkg::OFS_MASK)
                mask_reg <= pwdata[branch_unit_pkg::ST_BITS-1:0];
            if (paddr == branch_unit_pkg::OFS_CTRL)
                ctrl_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_target_reg <= 32'h00000000;
        else if (ev_taken)
            last_target_reg <= branch_target;
    end

    // Read data captured in setup so it is stable through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en)
            begin
                case (paddr)
                    branch_unit_pkg::OFS_STATUS:      prdata <= 32'(status_reg);
                    branch_unit_pkg::OFS_MASK:        prdata <= 32'(mask_reg);
                    branch_unit_pkg::OFS_CTRL:        prdata <= 32'(ctrl_reg);
                    branch_unit_pkg::OFS_LAST_TARGET: prdata <= last_target_reg;
                    default:                          prdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(status_reg & mask_reg);
    end

endmodule

// File: verif/branch_unit_chk_sva.sv
// Purpose: Port checker for the branch resolution block
// Assumes: Control bits are unseen, so an exception may excuse a branch
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
////////////////////////////////////////
module branch_unit_chk
#(
    parameter int CC_COUNT = 8
)
(
    // Clock, reset and issue side
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                issue_valid,
    input wire logic [31:0]         issue_instr,
    input wire logic [31:0]         issue_pc,
    input wire logic [CC_COUNT-1:0] fp_condition_bit,
    input wire logic                fp_unimpl,
    // Results
    input wire logic                redirect_valid,
    input wire logic [31:0]         redirect_pc,
    input wire logic                slot_nullify,
    input wire logic                link_we,
    input wire logic [4:0]          link_addr,
    input wire logic [31:0]         link_data,
    input wire logic                exc_cop_unusable,
    input wire logic                exc_reserved,
    input wire logic                exc_fp_unimpl
);
    logic        lnk;
    logic        fpb;
    logic        hit;
    logic        exc;
    logic [31:0] tgt;
    assign lnk = issue_valid && issue_instr[31:16] == 16'h0411;
    assign fpb = issue_valid && issue_instr[31:21] == 11'h228;
    assign hit = fp_condition_bit[issue_instr[20:18]] == issue_instr[16];
    assign exc = exc_cop_unusable || exc_reserved || exc_fp_unimpl;
    assign tgt = issue_pc + 32'h4 + {{14{issue_instr[15]}}, issue_instr[15:0], 2'h0};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_link_write: assert property (lnk |=> link_we && link_addr == 5'h1f
        && link_data == $past(issue_pc) + 32'h8) else $error("link write wrong");
    a_link_target: assert property (lnk |=> redirect_valid
        && redirect_pc == $past(tgt)) else $error("link target wrong");
    a_link_quiet: assert property (lnk |=> !exc && !slot_nullify)
        else $error("link raised an exception");
    a_miss_holds: assert property (fpb && !hit |=> !redirect_valid)
        else $error("untaken branch redirected");
    a_hit_redirect: assert property (fpb && hit |-> ##1 (exc
        || (redirect_valid && redirect_pc == $past(tgt)))) else $error("taken branch lost");
    a_likely_kill: assert property (fpb && !hit && issue_instr[17] |=> exc
        || slot_nullify) else $error("likely slot not nullified");
    a_plain_keep: assert property (fpb && !issue_instr[17] |=> !slot_nullify)
        else $error("plain branch nullified slot");
    a_unimpl_flag: assert property (fpb && fp_unimpl |=> exc)
        else $error("unimplemented case not reported");
    cover property (lnk);
    cover property (fpb && hit);
    cover property (fpb && !hit && issue_instr[17]);
endmodule

bind branch_link_fp_cond_unit branch_unit_chk #(.CC_COUNT(CC_COUNT)) u_chk (.pclk, .presetn,
    .issue_valid, .issue_instr, .issue_pc, .fp_condition_bit, .fp_unimpl, .redirect_valid,
    .redirect_pc, .slot_nullify, .link_we, .link_addr, .link_data, .exc_cop_unusable,
    .exc_reserved, .exc_fp_unimpl);

// File: verif/fpu_model.sv
// Purpose: Floating-point unit stand-in feeding condition bits
// Assumes: The bench calls compare to model a finished compare
// Notes:   Bits change only through compare, never through a branch
`timescale 1ns/1ps
////////////////////////////////////////
module fpu_model
(
    // Condition bits and fault flag
    output logic [7:0] fp_condition_bit,
    output logic       fp_unimpl
);
    initial
    begin
        fp_condition_bit = 8'h00;
        fp_unimpl = 1'b0;
    end
    task automatic compare(input logic [7:0] res);
        fp_condition_bit <= res;
    endtask
    task automatic set_unimpl(input logic v);
        fp_unimpl <= v;
    endtask
endmodule

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the branch resolution block
// Assumes: Zero-wait APB slave, results one cycle after issue
// Notes:   Delay slots stay empty, so no branch follows a branch
`timescale 1ns/1ps
////////////////////////////////////////
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        issue_valid = 1'b0;
    logic [31:0] issue_instr = 32'h0;
    logic [31:0] issue_pc = 32'h0;
    logic [7:0]  fp_condition_bit;
    logic        fp_unimpl;
    logic [31:0] prdata, redirect_pc, link_data;
    logic [4:0]  link_addr;
    logic        pready, pslverr, redirect_valid, slot_nullify, link_we;
    logic        exc_cop_unusable, exc_reserved, exc_fp_unimpl, irq;
    int          bad_count = 0;
    int          compares = 0;
    branch_link_fp_cond_unit #(.CC_COUNT(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .issue_valid, .issue_instr, .issue_pc,
        .fp_condition_bit, .fp_unimpl, .redirect_valid, .redirect_pc, .slot_nullify, .link_we,
        .link_addr, .link_data, .exc_cop_unusable, .exc_reserved, .exc_fp_unimpl, .irq);
    fpu_model u_fpu (.fp_condition_bit, .fp_unimpl);
    always #20 pclk = ~pclk;
    ////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // A read compares prdata with d; the error flag is always compared
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            bad_count++;
            stop_test();
        end
        if (!wr)
            check("prdata", prdata, d);
        check("pslverr", pslverr, err);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic issue(input logic [31:0] ins, input logic [31:0] pc);
        @(posedge pclk);
        issue_valid <= 1'b1;
        issue_instr <= ins;
        issue_pc <= pc;
        @(posedge pclk);
        issue_valid <= 1'b0;
        #1;
    endtask
    ////////////////////////////////////////
    initial
    begin
        logic [2:0] sel;
        logic [7:0] hot;
        logic       tk;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 8'h08, 32'h3, 1'b0);
        xfer(1'b0, 8'h04, 32'h0, 1'b0);
        xfer(1'b0, 8'h00, 32'h0, 1'b0);
        xfer(1'b0, 8'h10, 32'h0, 1'b1);
        xfer(1'b1, 8'h10, 32'hffffffff, 1'b1);
        $display("test registers done");
        issue(32'h0411fffe, 32'h00001000);
        check("link_we", link_we, 1'b1);
        check("link_addr", link_addr, 5'h1f);
        check("link_data", link_data, 32'h1008);
        check("redirect_valid", redirect_valid, 1'b1);
        check("redirect_pc", redirect_pc, 32'h0ffc);
        $display("test link done");
        for (int i = 0; i < 16; i++)
        begin
            sel = 3'(i * 3);
            hot = 8'h01 << sel;
            tk = i[2] == i[0];
            u_fpu.compare(i[2] ? hot : ~hot);
            issue({11'h228, sel, i[1], i[0], 16'h0010}, 32'h2000 + 32'(i * 16));
            check("redirect_valid", redirect_valid, tk);
            check("slot_nullify", slot_nullify, i[1] && !tk);
            if (tk)
                check("redirect_pc", redirect_pc, 32'h2044 + 32'(i * 16));
        end
        $display("test condition branches done");
        xfer(1'b0, 8'h00, 32'h3, 1'b0);
        check("irq", irq, 1'b0);
        xfer(1'b1, 8'h04, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        check("irq", irq, 1'b1);
        xfer(1'b1, 8'h00, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        check("irq", irq, 1'b0);
        xfer(1'b0, 8'h00, 32'h2, 1'b0);
        $display("test interrupt done");
        for (int j = 0; j < 3; j++)
        begin
            xfer(1'b1, 8'h08, 32'((1 << j) - 1), 1'b0);
            u_fpu.set_unimpl(j == 2);
            u_fpu.compare(8'hff);
            issue(32'h45010004, 32'h4000);
            check("exc", {exc_cop_unusable, exc_reserved, exc_fp_unimpl}, 3'b100 >> j);
            check("redirect_valid", redirect_valid, 1'b0);
        end
        xfer(1'b1, 8'h08, 32'h0, 1'b0);
        issue(32'h04110010, 32'h3000);
        check("exc", {exc_cop_unusable, exc_reserved, exc_fp_unimpl}, 3'b000);
        check("link_we", link_we, 1'b1);
        xfer(1'b0, 8'h0c, 32'h3044, 1'b0);
        $display("test exceptions done");
        stop_test();
    end
    initial
    begin
        #200000;
        bad_count++;
        stop_test();
    end
endmodule
